// [static_mem_ctrl.sv]
// Static memory controller front end: chip selects, address, strobes, lanes.
// Assumes one requester with a level request held until done_out pulses.
// Functional notes
// [RL1] Eight chip select outputs and a 26-bit external address bus.
// [RL2] Each chip select picks an 8-, 16- or 32-bit device width.
// [RL3] Active-low external wait stretches the current access while held; the code samples it only in the strobe pulse state.
// [RL4] Slow clock mode swaps programmed strobe timing for fixed slow timing.
// [RL5] Page mode burst reads of up to 32 bytes are supported.
// [RL6] Chip selects, strobes and byte selects are active low; wait too.
// [RL7] Each chip select spans 64 Mbytes; small devices repeat through it.
// [RL8] Significant address bits: 25:0 for 8-bit, 25:1 for 16, 25:2 for 32.
// [RL9] 16/32-bit chip selects use byte-write or byte-select per type field.
// [RL10] Byte-write on 16-bit: lower and upper write strobes, one read strobe.
// [RL11] Byte-write on 32-bit: four lane write strobes, one read strobe.
// [RL12] The boot chip select cannot use byte-write lane control.
// [RL13] Byte-select: one select per lane, single read and write strobes.
// [RL14] Byte-select uses two selects on 16-bit and four on 32-bit.
// [RL15] A0 shares lane-0 select; A1 shares lane-2 write and select.
// [RL16] Software routes shared pins to this function in the pin multiplexer.
// [RL17] Unused lane selects or upper write strobes for the mode stay unused.
// [RL18] Unused lane outputs are held inactive high during every access.
`timescale 1ns/100ps
`default_nettype none
module static_mem_ctrl
    import static_mem_ctrl_pkg::*;
#(
    parameter int BOOT_CS = 0
)
(
    input  wire logic                     clock_in,
    input  wire logic                     rst_in,
    input  wire logic                     clk_en_in,
    input  wire logic [NUM_CS*MODE_W-1:0] chip_select_mode_in,
    input  wire logic [NUM_CS*CNT_W-1:0]  setup_cycles_in,
    input  wire logic [NUM_CS*CNT_W-1:0]  pulse_cycles_in,
    input  wire logic [NUM_CS*CNT_W-1:0]  hold_cycles_in,
    input  wire logic                     slow_clock_mode_in,
    input  wire logic                     req_in,
    input  wire logic                     req_write_in,
    input  wire logic [2:0]               req_cs_in,
    input  wire logic [ADDR_W-1:0]        req_addr_in,
    input  wire logic [LANES-1:0]         req_byte_en_in,
    input  wire logic [DATA_W-1:0]        req_wdata_in,
    input  wire logic [PAGE_IDX_W-1:0]    req_burst_len_in,
    input  wire logic                     ext_wait_n_in,
    input  wire logic [DATA_W-1:0]        data_in,
    output logic [NUM_CS-1:0]             chip_sel_n_out,
    output logic [ADDR_W-1:2]             addr_out,
    output logic                          read_strobe_n_out,
    output logic                          lane0_select_n_out,
    output logic                          write_enable_n_out,
    output logic                          lane1_write_n_out,
    output logic                          lane2_write_n_out,
    output logic                          lane3_write_n_out,
    output logic [DATA_W-1:0]             data_out,
    output logic                          data_oe_n_out,
    output logic                          busy_out,
    output logic                          done_out,
    output logic                          rdata_valid_out,
    output logic [DATA_W-1:0]             rdata_out
);

    // ------------------------------------------------------------
    // Access sequencer states (Gray along idle-setup-pulse-hold)
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_SETUP = 2'b01,
        ST_PULSE = 2'b11,
        ST_HOLD  = 2'b10
    } state_t;

    state_t                state;
    state_t                next_state;
    logic [CNT_W-1:0]      cnt;
    logic [2:0]            cs;
    logic                  wr;
    logic [ADDR_W-1:0]     addr;
    logic [LANES-1:0]      ben;
    logic [PAGE_IDX_W-1:0] beats;
    logic [DATA_W-1:0]     wbuf;

    // ------------------------------------------------------------
    // Per chip select configuration decode
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] pick(input logic [NUM_CS*CNT_W-1:0] v,
                                               input logic [2:0] i);
        pick = v[i*CNT_W +: CNT_W];
    endfunction

    wire [MODE_W-1:0] mode = chip_select_mode_in[cs*MODE_W +: MODE_W];
    wire [1:0] width = mode[MODE_WIDTH_LO +: 2];                     // [RL2]
    // Boot chip select never runs byte-write lanes.
    wire lane_type = (cs == 3'(BOOT_CS)) ? LANE_BYTE_SELECT
                                         : mode[MODE_TYPE_BIT];      // [RL9] [RL12]
    // Slow clock mode overrides the programmed strobe timing.
    // Setup is looked up for the incoming request, since it is loaded as the request is taken.
    wire [CNT_W-1:0] t_setup = slow_clock_mode_in ? SLOW_SETUP
                                                  : pick(setup_cycles_in, req_cs_in); // [RL4]
    wire [CNT_W-1:0] t_pulse = slow_clock_mode_in ? SLOW_PULSE : pick(pulse_cycles_in, cs); // [RL4]
    wire [CNT_W-1:0] t_hold  = slow_clock_mode_in ? SLOW_HOLD  : pick(hold_cycles_in, cs);  // [RL4]
    wire waiting  = !ext_wait_n_in;                                  // [RL6]
    wire cnt_done = (cnt <= CNT_ONE);
    wire in_burst = (beats != '0);
    wire is32 = (width == WIDTH_32);
    wire is16 = (width == WIDTH_16);
    // Address step per beat follows the device width.
    wire [ADDR_W-1:0] step = is32 ? 26'h0000004 : (is16 ? 26'h0000002 : 26'h0000001);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:  if (req_in) next_state = ST_SETUP;
            ST_SETUP: if (cnt_done) next_state = ST_PULSE;
            // Wait extends the pulse; the strobe cannot end while held.
            ST_PULSE: if (cnt_done && !waiting)                      // [RL3]
                          next_state = (!wr && in_burst) ? ST_PULSE : ST_HOLD; // [RL5]
            ST_HOLD:  if (cnt_done) next_state = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            state <= ST_IDLE;
            cnt   <= '0;
            cs    <= '0;
            wr    <= 1'h0;
            addr  <= '0;
            ben   <= '0;
            beats <= '0;
            wbuf  <= '0;
        end
        else if (clk_en_in)
        begin
            state <= next_state;
            if (state == ST_IDLE && req_in)
            begin
                cs    <= req_cs_in;
                wr    <= req_write_in;
                addr  <= req_addr_in;                                // [RL7]
                ben   <= req_byte_en_in;
                wbuf  <= req_wdata_in;
                beats <= req_write_in ? '0 : req_burst_len_in;       // [RL5]
                cnt   <= t_setup;                                    // [RL4]
            end
            else if (next_state != state)
                cnt <= (next_state == ST_PULSE) ? t_pulse : t_hold;
            else if (state == ST_PULSE && cnt_done && !waiting && in_burst)
            begin
                // Next page beat: the whole address advances by one device width.
                addr  <= addr + step;                                // [RL5]
                beats <= beats - 1'h1;
                cnt   <= t_pulse;
            end
            else if (!cnt_done && !(state == ST_PULSE && waiting))
                cnt <= cnt - 1'h1;
        end
    end

    // ------------------------------------------------------------
    // Read capture and handshake
    // ------------------------------------------------------------
    wire beat_end = state == ST_PULSE && cnt_done && !waiting && clk_en_in;
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            rdata_out       <= '0;
            rdata_valid_out <= 1'h0;
            done_out        <= 1'h0;
        end
        else if (clk_en_in)
        begin
            rdata_valid_out <= beat_end && !wr;
            done_out        <= clk_en_in && state == ST_HOLD && cnt_done;
            if (beat_end && !wr)
                rdata_out <= data_in;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    wire active = (state != ST_IDLE);
    wire pulse  = (state == ST_PULSE);
    // Upper address bits only; narrow devices see the wrap naturally.
    assign addr_out          = addr[ADDR_W-1:2];                     // [RL1] [RL8]
    assign chip_sel_n_out    = ~({{(NUM_CS-1){1'h0}}, active} << cs); // [RL1] [RL6]
    assign read_strobe_n_out = ~(pulse && !wr);                      // [RL6]
    // Write data is held in a register so the bus stays put even if the requester moves on.
    assign data_out          = wbuf;
    assign data_oe_n_out     = ~(active && wr);
    assign busy_out          = active;

    lane_decode u_lanes
    (
        .width_in       (width),
        .lane_type_in   (lane_type),
        .addr_low_in    (addr[1:0]),                                 // [RL8]
        .byte_en_in     (ben),
        .active_in      (active),
        .write_pulse_in (pulse && wr),
        .pin_a0_out     (lane0_select_n_out),
        .pin_we_out     (write_enable_n_out),
        .pin_l1_out     (lane1_write_n_out),
        .pin_a1_out     (lane2_write_n_out),
        .pin_l3_out     (lane3_write_n_out)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_wait_held;
        pulse && waiting;
    endsequence

    chk_wait_holds_strobe: assert property (@(posedge clock_in) disable iff (rst_in) // [RL3]
        s_wait_held and clk_en_in |=> pulse)
        else $error("Strobe ended while wait held.");
    chk_one_cs_low: assert property (@(posedge clock_in) disable iff (rst_in) // [RL1]
        $countones(~chip_sel_n_out) <= 1)
        else $error("More than one chip select active.");
    chk_idle_high: assert property (@(posedge clock_in) disable iff (rst_in) // [RL6]
        !active |-> chip_sel_n_out == '1 && read_strobe_n_out)
        else $error("Control low while idle.");
    chk_boot_select: assert property (@(posedge clock_in) disable iff (rst_in) // [RL12]
        active && cs == 3'(BOOT_CS) && width != WIDTH_8 |-> lane0_select_n_out == !ben[0])
        else $error("Boot select in byte-write.");
    chk_upper_idle16: assert property (@(posedge clock_in) disable iff (rst_in) // [RL18]
        active && is16 |-> lane3_write_n_out)
        else $error("Unused lane 3 driven on 16-bit.");
    chk_no_read_on_wr: assert property (@(posedge clock_in) disable iff (rst_in) // [RL13]
        wr |-> read_strobe_n_out)
        else $error("Read strobe during write.");
    chk_slow_pulse: assert property (@(posedge clock_in) disable iff (rst_in) // [RL4]
        slow_clock_mode_in && clk_en_in && state == ST_SETUP && cnt_done
        |=> cnt == SLOW_PULSE)
        else $error("Slow pulse length wrong.");
    chk_burst_step: assert property (@(posedge clock_in) disable iff (rst_in) // [RL5]
        beat_end && in_burst && !wr |=> addr == $past(addr) + $past(step))
        else $error("Burst address step wrong.");

endmodule
`default_nettype wire

// [static_mem_ctrl_pkg.sv]
// Constants shared by the static memory controller front end.
// Assumes a single 100 MHz clock domain and no register bus.
package static_mem_ctrl_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_CS        = 8;
    localparam int ADDR_W        = 26;
    localparam int DATA_W        = 32;
    localparam int LANES         = 4;
    localparam int PAGE_MAX_BYTES = 32;
    localparam int PAGE_IDX_W    = 5;

    // ------------------------------------------------------------
    // Per chip select mode encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        WIDTH_8  = 2'h0,
        WIDTH_16 = 2'h1,
        WIDTH_32 = 2'h2
    } bus_width_t;

    localparam logic LANE_BYTE_SELECT = 1'h0;
    localparam logic LANE_BYTE_WRITE  = 1'h1;

    // Mode word layout: [1:0] width, [2] lane access type.
    localparam int MODE_W        = 3;
    localparam int MODE_WIDTH_LO = 0;
    localparam int MODE_TYPE_BIT = 2;

    // Default mode: 16-bit byte select, suitable for boot.
    localparam logic [MODE_W-1:0] MODE_RESET = 3'h1;

    // ------------------------------------------------------------
    // Strobe timing in master clock cycles
    // ------------------------------------------------------------
    localparam int CNT_W          = 4;
    localparam logic [CNT_W-1:0] SLOW_SETUP = 4'h1;
    localparam logic [CNT_W-1:0] SLOW_PULSE = 4'h1;
    localparam logic [CNT_W-1:0] SLOW_HOLD  = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;

endpackage

// [lane_decode.sv]
// Lane and low address pin multiplexer for the static memory controller.
// Assumes it is fed the current width, lane access type and strobe phase.
`timescale 1ns/100ps
`default_nettype none
module lane_decode
    import static_mem_ctrl_pkg::*;
(
    input  wire logic [1:0]       width_in,
    input  wire logic             lane_type_in,
    input  wire logic [1:0]       addr_low_in,
    input  wire logic [LANES-1:0] byte_en_in,
    input  wire logic             active_in,
    input  wire logic             write_pulse_in,
    output logic                  pin_a0_out,
    output logic                  pin_we_out,
    output logic                  pin_l1_out,
    output logic                  pin_a1_out,
    output logic                  pin_l3_out
);

    // ------------------------------------------------------------
    // Pin sharing
    // ------------------------------------------------------------
    wire is8   = (width_in == WIDTH_8);
    wire is16  = (width_in == WIDTH_16);
    wire is32  = (width_in == WIDTH_32);
    wire bwr   = lane_type_in == LANE_BYTE_WRITE && !is8;
    // Lane selects follow the address timing; write lanes follow the strobe.
    wire [LANES-1:0] sel_n = ~(byte_en_in & {LANES{active_in}});
    wire [LANES-1:0] wr_n  = ~(byte_en_in & {LANES{write_pulse_in}});

    // Address bit 0 on 8-bit, lane-0 select otherwise; unused selects idle high.
    assign pin_a0_out = is8 ? addr_low_in[0] : (bwr ? 1'h1 : sel_n[0]); // [RL15] [RL17] [RL18]
    // Single write enable unless byte-write lanes are in use.
    assign pin_we_out = bwr ? wr_n[0] : ~write_pulse_in;               // [RL10] [RL11] [RL13]
    assign pin_l1_out = is8 ? 1'h1 : (bwr ? wr_n[1] : sel_n[1]);        // [RL14] [RL18]
    // Address bit 1 on 8/16-bit, lane 2 strobe or select on 32-bit.
    assign pin_a1_out = !is32 ? addr_low_in[1] : (bwr ? wr_n[2] : sel_n[2]); // [RL15] [RL11]
    assign pin_l3_out = !is32 ? 1'h1 : (bwr ? wr_n[3] : sel_n[3]);      // [RL14] [RL17] [RL18]

endmodule
`default_nettype wire

// [mem_model.sv]
// Behavioural asynchronous memory standing on the far side of the controller.
// Assumes the bench sets how many cycles it stretches each strobe.
`timescale 1ns/100ps
`default_nettype none
module mem_model
    import static_mem_ctrl_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic [NUM_CS-1:0] chip_sel_n_in,
    input  wire logic [ADDR_W-1:2] addr_in,
    input  wire logic              read_strobe_n_in,
    input  wire logic              write_n_in,
    input  wire logic              lane0_in,
    input  wire logic              lane2_in,
    input  wire logic [3:0]        wait_len_in,
    output logic                   ext_wait_n_out,
    output logic [DATA_W-1:0]      data_out
);
    logic [3:0]        waited;
    logic [DATA_W-1:0] last;
    wire logic sel = !(&chip_sel_n_in);
    wire logic rd  = sel && !read_strobe_n_in;
    // Read data encodes the address seen; a released bus shows the inverse of its last word.
    assign data_out = rd ? {6'h00, addr_in, lane2_in, lane0_in} : ~last;
    // Wait is held low for the first cycles of each strobe, then let go.
    assign ext_wait_n_out = !(sel && (!read_strobe_n_in || !write_n_in) && waited < wait_len_in);
    // Count strobe cycles so the wait has a bounded length.
    always_ff @(posedge clock_in)
    begin
        waited <= (sel && (!read_strobe_n_in || !write_n_in)) ? waited + 4'h1 : 4'h0;
        last <= data_out;
    end
endmodule
`default_nettype wire

// [static_memory_bus_signal_mapping_tb.sv]
// Self-checking bench for the static memory controller front end.
// Assumes mem_model answers on the far side; clock enable drops now and then while idle.
`timescale 1ns/100ps
`default_nettype none
module static_memory_bus_signal_mapping_tb;
    import static_mem_ctrl_pkg::*;
    localparam int BOOT = 0;
    logic        clock_in, rst_in, slow, req, wr, ext_wait_n, rd_n, l0, we, l1, l2, l3;
    logic        oe_n, busy, done, rv, rw, clk_en;
    logic [23:0] mode;
    logic [31:0] setup, pulse, hold, wdata, din, dout, rdata;
    logic [25:0] addr, ra;
    logic [25:2] a_out;
    logic [7:0]  cs_n;
    logic [4:0]  blen, rn;
    logic [3:0]  be, wlen;
    logic [2:0]  cs, rm;
    int          bad_count, compares, pcnt, sc;
    integer      seed;

    static_mem_ctrl #(.BOOT_CS(BOOT)) DUT (.clock_in(clock_in), .rst_in(rst_in),
        .clk_en_in(clk_en), .chip_select_mode_in(mode), .setup_cycles_in(setup),
        .pulse_cycles_in(pulse), .hold_cycles_in(hold), .slow_clock_mode_in(slow),
        .req_in(req), .req_write_in(wr), .req_cs_in(cs), .req_addr_in(addr),
        .req_byte_en_in(be), .req_wdata_in(wdata), .req_burst_len_in(blen),
        .ext_wait_n_in(ext_wait_n), .data_in(din), .chip_sel_n_out(cs_n), .addr_out(a_out),
        .read_strobe_n_out(rd_n), .lane0_select_n_out(l0), .write_enable_n_out(we),
        .lane1_write_n_out(l1), .lane2_write_n_out(l2), .lane3_write_n_out(l3),
        .data_out(dout), .data_oe_n_out(oe_n), .busy_out(busy), .done_out(done),
        .rdata_valid_out(rv), .rdata_out(rdata));
    // The model sits on every shared pin, as if the pin multiplexer routed them here.
    mem_model partner (.clock_in(clock_in), .chip_sel_n_in(cs_n), .addr_in(a_out),
        .read_strobe_n_in(rd_n), .write_n_in(we), .lane0_in(l0), .lane2_in(l2),
        .wait_len_in(wlen), .ext_wait_n_out(ext_wait_n), .data_out(din));

    // ------------------------------------------------------------
    // Expectations
    // ------------------------------------------------------------
    // Pins {lane0, we, lane1, lane2, lane3}; w is low only in a write pulse.
    function automatic logic [4:0] exp_pins(input logic [2:0] m, input logic [2:0] c,
        input logic [1:0] a, input logic [3:0] b, input logic wrt, input logic pl);
        logic bw;
        logic w;
        bw = m[MODE_TYPE_BIT] == LANE_BYTE_WRITE && c != 3'(BOOT);
        w = !(wrt && pl);
        if (m[1:0] == WIDTH_8) return {a[0], w, 1'h1, a[1], 1'h1};
        if (m[1:0] == WIDTH_16)
            return bw ? {1'h1, w | ~b[0], w | ~b[1], a[1], 1'h1}
                      : {~b[0], w, ~b[1], a[1], 1'h1};
        return bw ? {1'h1, w | ~b[0], w | ~b[1], w | ~b[2], w | ~b[3]}
                  : {~b[0], w, ~b[1], ~b[2], ~b[3]};
    endfunction
    // The model echoes the address bits that the pins carry for this width.
    function automatic logic [31:0] rd_word(input logic [2:0] m, input logic [2:0] c,
        input logic [25:0] a, input logic [3:0] b);
        logic [4:0] p;
        p = exp_pins(m, c, a[1:0], b, 1'h0, 1'h0);
        return {6'h00, a[25:2], p[1], p[4]};
    endfunction
    // Selected cycle n lies in the strobe pulse: setup (zero counts as one), then pulse plus wait.
    function automatic logic in_pulse(input int n);
        int s;
        int w;
        s = slow ? int'(SLOW_SETUP) : (setup[cs*4 +: 4] == 4'h0) ? 1 : int'(setup[cs*4 +: 4]);
        w = (slow ? int'(SLOW_PULSE) : int'(pulse[cs*4 +: 4])) + int'(wlen);
        return n >= s && n < s + w;
    endfunction
    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'h1)
        begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Access driver and monitor
    // ------------------------------------------------------------
    // One access; the request is dropped as soon as done is seen so it is not taken again.
    task automatic access(input logic [2:0] c, input logic [2:0] m, input logic w,
        input logic [25:0] a, input logic [3:0] b, input logic [4:0] n);
        int t;
        int k;
        int p;
        logic [25:0] step;
        logic en;
        p = 1 + $unsigned($random(seed)) % 4;
        step = (m[1:0] == WIDTH_8) ? 26'h1 : (m[1:0] == WIDTH_16) ? 26'h2 : 26'h4;
        @(posedge clock_in);
        mode[c*3 +: 3] <= m;
        {cs, wr, addr, be, blen} <= {c, w, a, b, n};
        wdata <= $random(seed);
        setup <= $random(seed);
        pulse <= {8{4'(p)}};
        hold <= {8{4'(1 + $unsigned($random(seed)) % 3)}};
        wlen <= (n == 5'h00) ? 4'($unsigned($random(seed)) % 3) : 4'h0;
        slow <= ($random(seed) & 3) == 0;
        en = ($random(seed) & 7) != 0;
        clk_en <= en;
        @(posedge clock_in);
        {pcnt, k, t} = 0;
        req <= 1'h1;
        if (!en)
        begin
            // A request raised while the clock enable is low must not be taken.
            repeat (2) @(negedge clock_in);
            check(busy === 1'h0 && cs_n === 8'hFF, "frozen");
            @(posedge clock_in);
            clk_en <= 1'h1;
        end
        do
        begin
            @(negedge clock_in);
            t++;
            if (rv === 1'h1)
            begin
                check(rdata === rd_word(m, c, a + k * step, b), "beat data");
                k++;
            end
        end while (done !== 1'h1 && t < 600);
        req <= 1'h0;
        check(done === 1'h1, "done seen");
        if (!w) check(k == n + 1, "beat count");
        if (n == 5'h00) check(pcnt == (slow ? int'(SLOW_PULSE) : p) + wlen, "pulse");
    endtask
    // Single-beat accesses are watched every selected cycle at the settled point.
    always @(negedge clock_in)
    begin
        if (!rst_in && cs_n !== 8'hFF && blen == 5'h00)
        begin
            check(cs_n === ~(8'h01 << cs) && a_out === addr[25:2] && busy === 1'h1,
                "select");
            check({l0, we, l1, l2, l3} === exp_pins(mode[cs*3 +: 3], cs, addr[1:0], be, wr,
                in_pulse(sc)), "lanes");
            check(oe_n === !wr, "bus direction");
            if (wr) check(rd_n === 1'h1 && (we === 1'h1 || (dout === wdata && oe_n === 1'h0)),
                "write bus");
            if (rd_n === 1'h0 || (wr && we === 1'h0)) pcnt++;
            sc++;
        end
        else
            sc = 0;
    end

    // ------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial
    begin
        clock_in = 1'h0;
        forever #5 clock_in = ~clock_in;
    end
    // The longest run is well under this span; reaching it means a hang.
    initial
    begin
        repeat (80000) @(posedge clock_in);
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end
    initial
    begin
        seed = 32'hE318;
        {bad_count, compares} = 0;
        {rst_in, slow, req, wr, mode, setup, pulse, hold} = {1'h1, 123'h0};
        clk_en = 1'h1;
        {wdata, addr, be, wlen, blen, cs} = 0;
        repeat (6) @(posedge clock_in);
        rst_in <= 1'h0;
        @(negedge clock_in);
        check(cs_n === 8'hFF && rd_n === 1'h1 && we === 1'h1 && busy === 1'h0, "reset");
        $display("test reset done");
        // Corners: boot select asking byte write, full pages, top of the space.
        access(3'h0, 3'h6, 1'h1, 26'h3FFFFFF, 4'h3, 5'h00);
        access(3'h7, 3'h0, 1'h0, 26'h0000020, 4'hF, 5'h1F);
        access(3'h5, 3'h1, 1'h0, 26'h3FFFFE0, 4'hF, 5'h0F);
        access(3'h3, 3'h2, 1'h0, 26'h0000040, 4'h5, 5'h07);
        $display("test corners done");
        for (int i = 0; i < 80; i++)
        begin
            rm = {1'($random(seed)), 2'($unsigned($random(seed)) % 3)};
            rw = $random(seed);
            ra = $random(seed);
            rn = (rw || ($random(seed) & 1)) ? 5'h00 : 5'($unsigned($random(seed)) % (32 >> rm[1:0]));
            if (rn != 5'h00) ra[4:0] = 5'h00;
            access(3'($random(seed)), rm, rw, ra, 4'($random(seed)) | 4'h1, rn);
        end
        $display("test random done");
        give_verdict();
    end
endmodule
`default_nettype wire
